// ==== hdl/lbm_cfg.svh ====
// Offsets, reset values and timing counts of the leaky bucket monitor
`ifndef LBM_CFG_SVH
`define LBM_CFG_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define LBM_LEAK_RATE_SET1_ADDR 8'h00
`define LBM_ALARM_RAISE_SET2_ADDR 8'h04
`define LBM_BUCKET_SIZE_ADDR 8'h08
`define LBM_LEAK_RATE_SET2_ADDR 8'h0c
`define LBM_STATUS_ADDR 8'h10
`define LBM_IRQ_STAT_ADDR 8'h14
`define LBM_IRQ_MASK_ADDR 8'h18
// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define LBM_LEAK_RATE_SET1_RST 8'h01
`define LBM_ALARM_RAISE_SET2_RST 8'h06
`define LBM_BUCKET_SIZE_RST 8'h08
`define LBM_LEAK_RATE_SET2_RST 8'h01
`define LBM_LEAK_SEL_LSB 0
`define LBM_LEAK_SEL_MSB 1
`define LBM_IRQ_BITS 3
`define LBM_IRQ_ALARM_SET_BIT 0
`define LBM_IRQ_ALARM_CLR_BIT 1
`define LBM_IRQ_FAULT_BIT 2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LBM_EVAL_PERIOD_MS 128
`define LBM_CLK_HZ 125000000
`define LBM_EVAL_CYCLES ((`LBM_EVAL_PERIOD_MS * 64'd125000000) / 1000)
`endif

// ==== hdl/lbm_pkg.sv ====
// Types shared by the leaky bucket monitor files
package lbm_pkg;
	// One bucket's settings
	typedef struct packed {
		logic [1:0] leak_sel;
		logic [7:0] raise_level;
		logic [7:0] size_max;
	} lbm_bucket_cfg_t;
	// One bucket's visible state
	typedef struct packed {
		logic [7:0] level;
		logic alarm;
	} lbm_bucket_st_t;
	typedef enum logic [1:0] {LBM_IDLE, LBM_WDATA, LBM_WADDR, LBM_BRESP} lbm_wr_state_t;
endpackage

// ==== hdl/lbm_bucket.sv ====
// One leaky bucket accumulator with leak timer and saturation
`timescale 1ns/1ns
module lbm_bucket
	import lbm_pkg::*;
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic eval_tick, // One pulse per evaluation cycle
	input wire logic fault_seen, // Fault seen in this cycle
	input wire lbm_bucket_cfg_t cfg, // Bucket settings
	output lbm_bucket_st_t st // Level and alarm
);
	logic [7:0] level_ff, nxt_level;
	logic [2:0] clean_ff, nxt_clean;
	logic alarm_ff, nxt_alarm;

	// Clean cycles needed per leak: 1, 2, 4 or 8
	function automatic logic [3:0] leak_len(input logic [1:0] sel);
		leak_len = 4'h1 << sel;
	endfunction

	// Fill, leak and saturate once per evaluation cycle
	always_comb begin
		nxt_level = level_ff;
		nxt_clean = clean_ff;
		nxt_alarm = alarm_ff;
		if (eval_tick) begin
			if (fault_seen) begin
				nxt_clean = 3'h0;
				if (level_ff < cfg.size_max) begin
					nxt_level = level_ff + 8'h01;
				end
			end else if ({1'b0, clean_ff} + 4'h1 >= leak_len(cfg.leak_sel)) begin
				nxt_clean = 3'h0;
				if (level_ff != 8'h00) begin
					nxt_level = level_ff - 8'h01;
				end
			end else begin
				nxt_clean = clean_ff + 3'h1;
			end
			// Clamp if software shrank the size below the level
			if (nxt_level > cfg.size_max) begin
				nxt_level = cfg.size_max;
			end
		end
		// Alarm raised on reaching the level, dropped when empty
		if (nxt_level >= cfg.raise_level && cfg.raise_level != 8'h00) begin
			nxt_alarm = 1'b1;
		end else if (nxt_level == 8'h00) begin
			nxt_alarm = 1'b0;
		end
	end

	// State registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_ff <= 8'h00;
			clean_ff <= 3'h0;
			alarm_ff <= 1'b0;
		end else begin
			level_ff <= nxt_level;
			clean_ff <= nxt_clean;
			alarm_ff <= nxt_alarm;
		end
	end

	assign st.level = level_ff;
	assign st.alarm = alarm_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	level_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(eval_tick) |-> level_ff <= $past(cfg.size_max))
		else $error("bucket level above size");
	fill_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_tick && fault_seen && level_ff < cfg.size_max |=> level_ff == $past(level_ff) + 8'h01)
		else $error("fill step missing");
	hold_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!eval_tick |=> level_ff == $past(level_ff))
		else $error("level moved outside an evaluation");
	leak_every_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_tick && !fault_seen && cfg.leak_sel == 2'b00 && level_ff != 8'h00
		&& level_ff <= cfg.size_max |=> level_ff == $past(level_ff) - 8'h01)
		else $error("leak at code zero missing");
endmodule

// ==== hdl/lbm_monitor.sv ====
// Leaky bucket activity monitor with AXI4-Lite registers
// How it works
// - A fixed 128 ms evaluation cycle judges once per cycle whether the input faulted.
// - Each evaluation cycle with a fault adds one to the accumulator while it is below the bucket size.
// - One is removed after each run of 1, 2, 4 or 8 clean cycles chosen by a 2-bit code.
// - The set 1 leak selector resets to code 01, draining at half the fill rate.
// - At each evaluation the accumulator is clamped to the bucket size, which resets to 8.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "lbm_cfg.svh"
module lbm_monitor
	import lbm_pkg::*;
#(
	parameter logic [31:0] EVAL_CYCLES = 32'(`LBM_EVAL_CYCLES)
)(
	input wire logic aclk, // 125 MHz clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ref_fault, // Fault or erratic pulse from the clock monitor
	output logic inactivity_alarm, // Set 2 alarm to reference selection
	output logic irq, // Level interrupt
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	// ----------------------------------------------------------------
	// Evaluation timer and fault capture
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt_ff, nxt_tick_cnt;
	logic fault_ff, nxt_fault;
	logic eval_tick;

	// Faults between ticks are latched so a short glitch still counts
	always_comb begin
		eval_tick = (tick_cnt_ff == EVAL_CYCLES - 32'h1);
		nxt_tick_cnt = eval_tick ? 32'h0 : tick_cnt_ff + 32'h1;
		nxt_fault = eval_tick ? 1'b0 : (fault_ff | ref_fault); // Tick cycle fault counts once
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_ff <= 32'h0;
			fault_ff <= 1'b0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
			fault_ff <= nxt_fault;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [1:0] leak1_ff, nxt_leak1, leak2_ff, nxt_leak2;
	logic [7:0] raise2_ff, nxt_raise2, size_ff, nxt_size;
	logic [`LBM_IRQ_BITS-1:0] istat_ff, nxt_istat, imask_ff, nxt_imask, ev;
	lbm_bucket_cfg_t cfg1, cfg2;
	lbm_bucket_st_t st1, st2;
	logic alarm2_q_ff;

	// Set 1 has no alarm of its own here; its raise level is left off
	assign cfg1 = '{leak_sel: leak1_ff, raise_level: 8'h00, size_max: size_ff};
	assign cfg2 = '{leak_sel: leak2_ff, raise_level: raise2_ff, size_max: size_ff};

	// ----------------------------------------------------------------
	// Bucket instances
	// ----------------------------------------------------------------
	lbm_bucket u_bucket1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.eval_tick(eval_tick),
		.fault_seen(fault_ff | ref_fault),
		.cfg(cfg1),
		.st(st1)
	);
	lbm_bucket u_bucket2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.eval_tick(eval_tick),
		.fault_seen(fault_ff | ref_fault),
		.cfg(cfg2),
		.st(st2)
	);

	assign inactivity_alarm = st2.alarm;

	// ----------------------------------------------------------------
	// AXI4-Lite write side
	// ----------------------------------------------------------------
	lbm_wr_state_t wst_ff, nxt_wst;
	logic [7:0] waddr_ff, nxt_waddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [1:0] bresp_ff, nxt_bresp;
	logic do_write;
	logic [7:0] wa;
	logic [31:0] wd;
	logic ws;
	logic wstrb0_ff, nxt_wstrb0;

	// Address decode shared by both directions
	function automatic logic addr_ok(input logic [7:0] a);
		case (a)
			`LBM_LEAK_RATE_SET1_ADDR, `LBM_ALARM_RAISE_SET2_ADDR, `LBM_BUCKET_SIZE_ADDR,
			`LBM_LEAK_RATE_SET2_ADDR, `LBM_STATUS_ADDR, `LBM_IRQ_STAT_ADDR,
			`LBM_IRQ_MASK_ADDR: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	endfunction

	// Address and data accepted in either order; response after both
	always_comb begin
		nxt_wst = wst_ff;
		nxt_waddr = waddr_ff;
		nxt_wdata = wdata_ff;
		nxt_bresp = bresp_ff;
		nxt_wstrb0 = wstrb0_ff;
		do_write = 1'b0;
		// Buffered halves come from flops, live halves from the bus
		wa = (wst_ff == LBM_WDATA) ? waddr_ff : s_axi_awaddr;
		wd = (wst_ff == LBM_WADDR) ? wdata_ff : s_axi_wdata;
		ws = (wst_ff == LBM_WADDR) ? wstrb0_ff : s_axi_wstrb[0];
		s_axi_awready = (wst_ff == LBM_IDLE) || (wst_ff == LBM_WADDR);
		s_axi_wready = (wst_ff == LBM_IDLE) || (wst_ff == LBM_WDATA);
		case (wst_ff)
			LBM_IDLE: begin
				if (s_axi_awvalid && s_axi_wvalid) begin
					do_write = 1'b1;
				end else if (s_axi_awvalid) begin
					nxt_waddr = s_axi_awaddr;
					nxt_wst = LBM_WDATA;
				end else if (s_axi_wvalid) begin
					nxt_wdata = s_axi_wdata;
					nxt_wstrb0 = s_axi_wstrb[0];
					nxt_wst = LBM_WADDR;
				end
			end
			LBM_WDATA: do_write = s_axi_wvalid;
			LBM_WADDR: do_write = s_axi_awvalid;
			LBM_BRESP: if (s_axi_bready) nxt_wst = LBM_IDLE;
			default: nxt_wst = LBM_IDLE;
		endcase
		if (do_write) begin
			nxt_bresp = addr_ok(wa) ? 2'b00 : 2'b10;
			nxt_wst = LBM_BRESP;
		end
	end

	assign s_axi_bvalid = (wst_ff == LBM_BRESP);
	assign s_axi_bresp = bresp_ff;

	// Register writes; strobe lane 0 carries every field
	always_comb begin
		nxt_leak1 = leak1_ff;
		nxt_leak2 = leak2_ff;
		nxt_raise2 = raise2_ff;
		nxt_size = size_ff;
		nxt_imask = imask_ff;
		nxt_istat = istat_ff;
		ev = '0;
		ev[`LBM_IRQ_ALARM_SET_BIT] = st2.alarm & ~alarm2_q_ff;
		ev[`LBM_IRQ_ALARM_CLR_BIT] = ~st2.alarm & alarm2_q_ff;
		ev[`LBM_IRQ_FAULT_BIT] = eval_tick & (fault_ff | ref_fault);
		if (do_write && ws) begin
			case (wa)
				`LBM_LEAK_RATE_SET1_ADDR: nxt_leak1 = wd[`LBM_LEAK_SEL_MSB:`LBM_LEAK_SEL_LSB];
				`LBM_LEAK_RATE_SET2_ADDR: nxt_leak2 = wd[`LBM_LEAK_SEL_MSB:`LBM_LEAK_SEL_LSB];
				`LBM_ALARM_RAISE_SET2_ADDR: nxt_raise2 = wd[7:0];
				`LBM_BUCKET_SIZE_ADDR: nxt_size = wd[7:0];
				`LBM_IRQ_MASK_ADDR: nxt_imask = wd[`LBM_IRQ_BITS-1:0];
				`LBM_IRQ_STAT_ADDR: nxt_istat = istat_ff & ~wd[`LBM_IRQ_BITS-1:0];
				default: nxt_istat = istat_ff;
			endcase
		end
		// Set after clear, so a new event is never lost
		nxt_istat = nxt_istat | ev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_ff <= LBM_IDLE;
			waddr_ff <= 8'h00;
			wdata_ff <= 32'h0;
			wstrb0_ff <= 1'b0;
			bresp_ff <= 2'b00;
			leak1_ff <= 2'(`LBM_LEAK_RATE_SET1_RST);
			leak2_ff <= 2'(`LBM_LEAK_RATE_SET2_RST);
			raise2_ff <= `LBM_ALARM_RAISE_SET2_RST;
			size_ff <= `LBM_BUCKET_SIZE_RST;
			imask_ff <= '0;
			istat_ff <= '0;
			alarm2_q_ff <= 1'b0;
		end else begin
			wst_ff <= nxt_wst;
			waddr_ff <= nxt_waddr;
			wdata_ff <= nxt_wdata;
			wstrb0_ff <= nxt_wstrb0;
			bresp_ff <= nxt_bresp;
			leak1_ff <= nxt_leak1;
			leak2_ff <= nxt_leak2;
			raise2_ff <= nxt_raise2;
			size_ff <= nxt_size;
			imask_ff <= nxt_imask;
			istat_ff <= nxt_istat;
			alarm2_q_ff <= st2.alarm;
		end
	end

	assign irq = |(istat_ff & imask_ff);

	// ----------------------------------------------------------------
	// AXI4-Lite read side
	// ----------------------------------------------------------------
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;

	// One read at a time; data registered one cycle after the address
	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		s_axi_arready = !rvalid_ff;
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
			case (s_axi_araddr)
				`LBM_LEAK_RATE_SET1_ADDR: nxt_rdata = {30'h0, leak1_ff};
				`LBM_LEAK_RATE_SET2_ADDR: nxt_rdata = {30'h0, leak2_ff};
				`LBM_ALARM_RAISE_SET2_ADDR: nxt_rdata = {24'h0, raise2_ff};
				`LBM_BUCKET_SIZE_ADDR: nxt_rdata = {24'h0, size_ff};
				`LBM_STATUS_ADDR: nxt_rdata = {15'h0, st2.alarm, st2.level, st1.level};
				`LBM_IRQ_STAT_ADDR: nxt_rdata = {29'h0, istat_ff};
				`LBM_IRQ_MASK_ADDR: nxt_rdata = {29'h0, imask_ff};
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= 2'b00;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	tick_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_tick |=> !eval_tick && tick_cnt_ff == 32'h0)
		else $error("evaluation tick not periodic");
	leak_reset_a: assert property (@(posedge aclk)
		!aresetn |=> leak1_ff == 2'b01)
		else $error("set 1 leak code not 01 after reset");
	raise_reset_a: assert property (@(posedge aclk)
		!aresetn |=> raise2_ff == 8'h06 && size_ff == 8'h08)
		else $error("set 2 raise level or size wrong after reset");
	alarm_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st2.level >= raise2_ff && raise2_ff != 8'h00 && !$changed(raise2_ff) |-> inactivity_alarm)
		else $error("alarm low at raise level");
	irq_stick_a: assert property (@(posedge aclk) disable iff (!aresetn)
		istat_ff[`LBM_IRQ_FAULT_BIT] && !do_write |=> istat_ff[`LBM_IRQ_FAULT_BIT])
		else $error("status bit dropped without a clear");
	set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ev[`LBM_IRQ_FAULT_BIT] |=> istat_ff[`LBM_IRQ_FAULT_BIT])
		else $error("status event lost to a clear");
	busy_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	read_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	alarm_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st2.level == 8'h00 |-> !inactivity_alarm)
		else $error("alarm high with empty bucket");
	fill_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_tick |=> {1'b0, st1.level} <= {1'b0, $past(st1.level)} + 9'h001)
		else $error("bucket rose by more than one");
	leak_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_tick && !(fault_ff | ref_fault) |=> st2.level <= $past(st2.level))
		else $error("bucket rose in a clean cycle");
	fault_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ref_fault && !eval_tick |=> fault_ff)
		else $error("fault not held until the evaluation");
	fault_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_tick |=> !fault_ff)
		else $error("fault carried into the next cycle");
endmodule

// ==== dv/leaky_bucket_activity_monitor_tb_top.sv ====
// Self-checking bench for the leaky bucket monitor over its register bus
`timescale 1ns/1ns
`include "lbm_cfg.svh"
module leaky_bucket_activity_monitor_tb_top;
	import lbm_pkg::*;
	// ----------------------------------------------------------------
	// Signals and bench state
	// ----------------------------------------------------------------
	localparam int EVAL = 20;
	logic aclk, aresetn, ref_fault, inactivity_alarm, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int err_total, checks, cyc, sz, rs;
	int lvl [2], clean [2], code [2];
	logic alm;
	logic [7:0] rst_addr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
	logic [31:0] rst_val [7] = '{32'h01, 32'h06, 32'h08, 32'h01, 32'h00, 32'h00, 32'h00};

	lbm_monitor #(.EVAL_CYCLES(32'(EVAL))) lbm_monitor_i (
		.aclk(aclk), .aresetn(aresetn), .ref_fault(ref_fault),
		.inactivity_alarm(inactivity_alarm), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	// ----------------------------------------------------------------
	// Clock, cycle count and hang guard
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Whole run needs about 1300 cycles; double that is a hang
	always @(posedge aclk) begin
		cyc <= aresetn ? cyc + 1 : 0;
		if (cyc == 2600) begin
			err_total++;
			complete_run;
		end
	end

	// ----------------------------------------------------------------
	// Compare, bus and evaluation-cycle tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Ready signals stay high, so the response is taken as soon as it shows
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw, hb;
		logic [1:0] br;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(negedge aclk);
			ha = s_axi_awvalid & s_axi_awready;
			hw = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
		end
		chk("bresp", {30'h0, er}, {30'h0, br});
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic h;
		logic [1:0] r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		h = 1'b0;
		while (!h) begin
			@(negedge aclk);
			h = s_axi_arvalid & s_axi_arready;
			@(posedge aclk);
			if (h) s_axi_arvalid <= 1'b0;
		end
		h = 1'b0;
		while (!h) begin
			@(negedge aclk);
			h = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask
	// Early in each evaluation cycle: check levels, optionally fault, then step the model
	task period(input bit f);
		do @(posedge aclk); while (cyc % EVAL != 3);
		rd(`LBM_STATUS_ADDR, rd_val, 2'b00);
		chk("status", {15'h0, alm, lvl[1][7:0], lvl[0][7:0]}, rd_val);
		chk("alarm pin", {31'h0, alm}, {31'h0, inactivity_alarm});
		if (f) begin
			ref_fault <= 1'b1;
			@(posedge aclk);
			ref_fault <= 1'b0;
			@(posedge aclk);
		end
		// Both sets fill together but each leaks by its own code
		for (int s = 0; s < 2; s++) begin
			if (f) begin
				lvl[s] = (lvl[s] < sz) ? lvl[s] + 1 : sz;
				clean[s] = 0;
			end else begin
				clean[s]++;
				if (clean[s] == (1 << code[s])) begin
					clean[s] = 0;
					if (lvl[s] > 0) lvl[s]--;
				end
			end
		end
		if (lvl[1] >= rs) alm = 1'b1;
		else if (lvl[1] == 0) alm = 1'b0;
	endtask
	task complete_run;
		if (err_total == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{aresetn, ref_fault, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		err_total = 0;
		checks = 0;
		lvl = '{0, 0};
		clean = '{0, 0};
		code = '{1, 1};
		sz = 8;
		rs = 6;
		alm = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 7; i++) begin
			rd(rst_addr[i], rd_val, 2'b00);
			chk("reset value", rst_val[i], rd_val);
		end
		// Unmapped place answers with an error and reads zero
		rd(8'h1c, rd_val, 2'b10);
		chk("unmapped read", 32'h0, rd_val);
		wr(8'h1c, 32'hff, 2'b10);
		// Narrow fields keep only their own bits
		wr(`LBM_ALARM_RAISE_SET2_ADDR, 32'hffffff0a, 2'b00);
		rd(`LBM_ALARM_RAISE_SET2_ADDR, rd_val, 2'b00);
		chk("raise level", 32'h0a, rd_val);
		wr(`LBM_ALARM_RAISE_SET2_ADDR, 32'h06, 2'b00);
		wr(`LBM_LEAK_RATE_SET1_ADDR, 32'hfffffffe, 2'b00);
		rd(`LBM_LEAK_RATE_SET1_ADDR, rd_val, 2'b00);
		chk("leak code", 32'h02, rd_val);
		wr(`LBM_LEAK_RATE_SET1_ADDR, 32'h01, 2'b00);
		// Fill past the size to see saturation and the alarm at six
		for (int i = 0; i < 10; i++) period(1'b1);
		// Every leak code, the fault cycle restarting the clean run; last pass drains to zero
		for (int c = 0; c < 5; c++) begin
			period(1'b1);
			wr(`LBM_LEAK_RATE_SET1_ADDR, 32'(c % 4), 2'b00);
			wr(`LBM_LEAK_RATE_SET2_ADDR, 32'(c % 4), 2'b00);
			code = '{c % 4, c % 4};
			repeat ((c == 4) ? 5 : (2 << code[0])) period(1'b0);
		end
		// Smaller size and raise level; then set 2 leaks slower than set 1
		sz = 3;
		rs = 2;
		wr(`LBM_BUCKET_SIZE_ADDR, 32'h03, 2'b00);
		wr(`LBM_ALARM_RAISE_SET2_ADDR, 32'h02, 2'b00);
		repeat (4) period(1'b1);
		wr(`LBM_LEAK_RATE_SET2_ADDR, 32'h02, 2'b00);
		code[1] = 2;
		repeat (5) period(1'b0);
		// Sticky events: rise, fall and faulty cycles all seen
		rd(`LBM_IRQ_STAT_ADDR, rd_val, 2'b00);
		chk("irq status", 32'h07, rd_val);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`LBM_IRQ_STAT_ADDR, 32'h03, 2'b00);
		wr(`LBM_IRQ_MASK_ADDR, 32'h03, 2'b00);
		chk("irq other bits", 32'h0, {31'h0, irq});
		wr(`LBM_IRQ_MASK_ADDR, 32'h04, 2'b00);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(`LBM_IRQ_STAT_ADDR, 32'h04, 2'b00);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(`LBM_IRQ_STAT_ADDR, rd_val, 2'b00);
		chk("irq status clear", 32'h0, rd_val);
		complete_run;
	end
endmodule
